// ===== logic/msdls_pkg.sv
/*
  Shared constants and types of the mode strap decoder and LED status
  block: register indices, field positions, reset values, mode codes,
  strap levels, LED scheme codes and blink timing.
  Assumes one 40 MHz clock and a 32-bit Avalon-MM register bus.
*/
package msdls_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned BLINK_HALF_MS   = 125;
  localparam int unsigned MIX_HALF_US     = 500;
  localparam int unsigned STRETCH_MS      = 50;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned MIX_HALF_CYC    = CLK_HZ / 1_000_000 * MIX_HALF_US;
  localparam int unsigned STRETCH_CYC     = CLK_HZ / 1000 * STRETCH_MS;

  // register indices; byte address is four times the index
  localparam int unsigned REG_CTRL_IDX    = 0;
  localparam int unsigned REG_ADV_IDX     = 4;
  localparam int unsigned REG_GIG_IDX     = 9;
  localparam int unsigned REG_MODE_IDX    = 19;
  localparam int unsigned REG_STAT_IDX    = 31;
  localparam logic [7:0]  ADDR_CTRL       = 8'(REG_CTRL_IDX * 4);
  localparam logic [7:0]  ADDR_ADV        = 8'(REG_ADV_IDX * 4);
  localparam logic [7:0]  ADDR_GIG        = 8'(REG_GIG_IDX * 4);
  localparam logic [7:0]  ADDR_MODE       = 8'(REG_MODE_IDX * 4);
  localparam logic [7:0]  ADDR_STAT       = 8'(REG_STAT_IDX * 4);

  // field positions
  localparam int unsigned CTRL_SRST_BIT   = 15;
  localparam int unsigned CTRL_SPD0_BIT   = 13;
  localparam int unsigned CTRL_ANEN_BIT   = 12;
  localparam int unsigned CTRL_DUP_BIT    = 8;
  localparam int unsigned CTRL_SPD1_BIT   = 6;
  localparam int unsigned ADV_HI          = 8;
  localparam int unsigned ADV_LO          = 5;
  localparam int unsigned GIG_HI          = 12;
  localparam int unsigned GIG_MID         = 9;
  localparam int unsigned GIG_LO          = 8;
  localparam int unsigned MODE_HI         = 15;
  localparam int unsigned MODE_LO         = 11;
  localparam int unsigned LEDS_HI         = 4;
  localparam int unsigned LEDS_LO         = 3;

  // reset values
  localparam logic [15:0] CTRL_RST        = 16'h0000;
  localparam logic [15:0] ADV_RST         = 16'h0000;
  localparam logic [15:0] GIG_RST         = 16'h0000;
  localparam logic [4:0]  MODE_RST        = 5'h07;
  localparam logic [1:0]  LEDS_RST        = 2'h3;

  // operating mode codes
  localparam logic [4:0]  OPM_10_HALF     = 5'h00;
  localparam logic [4:0]  OPM_10_FULL     = 5'h01;
  localparam logic [4:0]  OPM_100_HALF    = 5'h02;
  localparam logic [4:0]  OPM_100_FULL    = 5'h03;
  localparam logic [4:0]  OPM_AUTO_10_100 = 5'h04;
  localparam logic [4:0]  OPM_AUTO_ALL    = 5'h07;
  localparam logic [4:0]  OPM_MAN_SLAVE   = 5'h09;
  localparam logic [4:0]  OPM_MAN_MASTER  = 5'h0A;

  // preset patterns
  localparam logic [3:0]  ADV_ALL         = 4'hF;
  localparam logic [4:0]  GIG_AUTO        = 5'h03;
  localparam logic [4:0]  GIG_SLAVE       = 5'h13;
  localparam logic [4:0]  GIG_MASTER      = 5'h1F;

  // strap levels
  localparam logic [1:0]  LVL_GND         = 2'h0;
  localparam logic [1:0]  LVL_FAST        = 2'h1;
  localparam logic [1:0]  LVL_GIG         = 2'h2;
  localparam logic [1:0]  LVL_VDD         = 2'h3;

  // led schemes and link speeds
  localparam logic [1:0]  LEDS_ONE        = 2'h1;
  localparam logic [1:0]  LEDS_TWO        = 2'h2;
  localparam logic [1:0]  SPD_10          = 2'h0;
  localparam logic [1:0]  SPD_100         = 2'h1;
  localparam logic [1:0]  SPD_1000        = 2'h2;

  typedef struct packed {
    logic       link_up;
    logic [1:0] speed;
    logic       duplex_resolved;
    logic       duplex_full;
    logic       tx_active;
    logic       rx_active;
    logic       collision;
  } msdls_link_s;

  typedef struct packed {
    logic gig;
    logic fast;
    logic base;
    logic duplex;
  } msdls_led_s;

  typedef enum logic [1:0] {
    MSDLS_ST_RESET = 2'b00,
    MSDLS_ST_LOAD  = 2'b01,
    MSDLS_ST_RUN   = 2'b11
  } msdls_state_e;

endpackage

// ===== logic/msdls_blink.sv
/*
  Blink, colour-mix and activity-stretch timing for the status LEDs.
  Assumes the caller's clock enable and active-low asynchronous reset.
*/
`timescale 1ns/10ps
module msdls_blink
  import msdls_pkg::*;
#(
  parameter int unsigned BLINK_CYC   = BLINK_HALF_CYC,
  parameter int unsigned MIX_CYC     = MIX_HALF_CYC,
  parameter int unsigned STRETCH_LEN = STRETCH_CYC
)(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic act_in,
  output logic      blink_phase,
  output logic      mix_phase,
  output logic      act_stretched
);

  logic [31:0] blink_cnt_reg;
  logic [31:0] mix_cnt_reg;
  logic [31:0] str_cnt_reg;

  if (BLINK_CYC < 1 || MIX_CYC < 1 || STRETCH_LEN < 1)
  begin : g_chk
    $error("msdls_blink: counts must be at least one");
  end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      blink_cnt_reg <= 32'h0;
      blink_phase   <= 1'b0;
    end
    else if (ce)
    begin
      if (blink_cnt_reg == BLINK_CYC - 1)
      begin
        blink_cnt_reg <= 32'h0;
        blink_phase   <= ~blink_phase;
      end
      else
        blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end

  // 50 percent alternation for the mixed colour
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      mix_cnt_reg <= 32'h0;
      mix_phase   <= 1'b0;
    end
    else if (ce)
    begin
      if (mix_cnt_reg == MIX_CYC - 1)
      begin
        mix_cnt_reg <= 32'h0;
        mix_phase   <= ~mix_phase;
      end
      else
        mix_cnt_reg <= mix_cnt_reg + 32'h1;
    end

  // short bursts held long enough to be seen
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      str_cnt_reg   <= 32'h0;
      act_stretched <= 1'b0;
    end
    else if (ce)
    begin
      if (act_in)
        str_cnt_reg <= STRETCH_LEN;
      else if (str_cnt_reg != 32'h0)
        str_cnt_reg <= str_cnt_reg - 32'h1;
      act_stretched <= act_in | (str_cnt_reg > 32'h1);
    end

endmodule

// ===== logic/msdls_top.sv
/*
  Mode strap decoder and LED status driver: loads the operating mode
  and dependent presets from the two four-level mode pins after reset,
  keeps the control, advertisement, gigabit and mode registers behind an
  Avalon-MM slave, drives carrier sense and the four status LEDs.
  Assumes pin levels already resolved to two bits and synchronous.
*/
`timescale 1ns/10ps
module msdls_top
  import msdls_pkg::*;
#(
  parameter int unsigned BLINK_CYC   = BLINK_HALF_CYC,
  parameter int unsigned MIX_CYC     = MIX_HALF_CYC,
  parameter int unsigned STRETCH_LEN = STRETCH_CYC
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [1:0]  mode_pin_upper,
  input  wire logic [1:0]  mode_pin_lower,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire msdls_link_s link_in,
  output logic             carrier_sense_out,
  output msdls_led_s       led_out
);

  msdls_state_e state_reg;
  logic [15:0]  ctrl_reg;
  logic [15:0]  adv_reg;
  logic [15:0]  gig_reg;
  logic [4:0]   operating_mode_field;
  logic [1:0]   indicator_scheme_select;
  logic         ack_reg;
  logic [15:0]  ctrl_pre;
  logic [15:0]  adv_pre;
  logic [15:0]  gig_pre;
  logic [4:0]   mode_dec;
  logic         load_now;
  logic         wr_fire;
  logic         rd_fire;
  logic [15:0]  rd_val;
  logic         blink_phase;
  logic         mix_phase;
  logic         act_str;
  logic         act_raw;
  logic         full_dup;
  logic         s10;
  logic         s100;
  logic         s1000;
  logic         dfull;
  logic         act_on;

  // pin levels to mode code; undefined upper levels fall back to auto
  function automatic logic [4:0] mode_from_pins(input logic [1:0] up,
                                                input logic [1:0] lo);
    logic [4:0] m;
    m = OPM_AUTO_ALL;
    if (up == LVL_GIG)
    begin
      case (lo)
        LVL_GND:  m = OPM_10_HALF;
        LVL_FAST: m = OPM_10_FULL;
        LVL_GIG:  m = OPM_100_HALF;
        default:  m = OPM_100_FULL;
      endcase
    end
    else if (up == LVL_VDD)
    begin
      case (lo)
        LVL_GND:  m = OPM_AUTO_ALL;
        LVL_FAST: m = OPM_AUTO_10_100;
        LVL_GIG:  m = OPM_MAN_SLAVE;
        default:  m = OPM_MAN_MASTER;
      endcase
    end
    return m;
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0])
      r[7:0] = wd[7:0];
    if (be[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  assign mode_dec = mode_from_pins(mode_pin_upper, mode_pin_lower);
  assign load_now = ce && (state_reg == MSDLS_ST_LOAD);
  assign wr_fire  = ce && avs_write && ack_reg;
  assign rd_fire  = ce && avs_read && !ack_reg;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  // presets derived from the decoded mode
  always_comb
  begin
    ctrl_pre = ctrl_reg;
    adv_pre  = adv_reg;
    gig_pre  = gig_reg;
    gig_pre[GIG_MID:GIG_LO] = 2'h0;
    case (mode_dec)
      OPM_10_HALF, OPM_10_FULL, OPM_100_HALF, OPM_100_FULL:
      begin
        ctrl_pre[CTRL_SPD0_BIT] = mode_dec[1];
        ctrl_pre[CTRL_ANEN_BIT] = 1'b0;
        ctrl_pre[CTRL_DUP_BIT]  = mode_dec[0];
        ctrl_pre[CTRL_SPD1_BIT] = 1'b0;
      end
      OPM_AUTO_10_100:
      begin
        ctrl_pre[CTRL_SPD0_BIT] = 1'b1;
        ctrl_pre[CTRL_ANEN_BIT] = 1'b1;
        ctrl_pre[CTRL_SPD1_BIT] = 1'b0;
        adv_pre[ADV_HI:ADV_LO]  = ADV_ALL;
      end
      default:
      begin
        ctrl_pre[CTRL_SPD0_BIT] = 1'b0;
        ctrl_pre[CTRL_ANEN_BIT] = 1'b1;
        ctrl_pre[CTRL_SPD1_BIT] = 1'b1;
        adv_pre[ADV_HI:ADV_LO]  = ADV_ALL;
        case (mode_dec)
          OPM_MAN_SLAVE:  gig_pre[GIG_HI:GIG_LO] = GIG_SLAVE;
          OPM_MAN_MASTER: gig_pre[GIG_HI:GIG_LO] = GIG_MASTER;
          default:        gig_pre[GIG_HI:GIG_LO] = GIG_AUTO;
        endcase
      end
    endcase
  end

  // strap load sequence: one load right after reset release
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      state_reg <= MSDLS_ST_RESET;
    else if (ce)
    begin
      case (state_reg)
        MSDLS_ST_RESET: state_reg <= MSDLS_ST_LOAD;
        MSDLS_ST_LOAD:  state_reg <= MSDLS_ST_RUN;
        MSDLS_ST_RUN:   state_reg <= MSDLS_ST_RUN;
        default:        state_reg <= MSDLS_ST_RESET;
      endcase
    end

  // control register; soft reset bit self-clears, nothing else reloads
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      ctrl_reg <= CTRL_RST;
    else if (load_now)
      ctrl_reg <= ctrl_pre;
    else if (wr_fire && avs_address == ADDR_CTRL)
    begin
      ctrl_reg <= lane_merge(ctrl_reg, avs_writedata[15:0],
                             avs_byteenable[1:0]);
    end
    else if (ce)
      ctrl_reg[CTRL_SRST_BIT] <= 1'b0;

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      adv_reg <= ADV_RST;
    else if (load_now)
      adv_reg <= adv_pre;
    else if (wr_fire && avs_address == ADDR_ADV)
      adv_reg <= lane_merge(adv_reg, avs_writedata[15:0], avs_byteenable[1:0]);

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      gig_reg <= GIG_RST;
    else if (load_now)
      gig_reg <= gig_pre;
    else if (wr_fire && avs_address == ADDR_GIG)
      gig_reg <= lane_merge(gig_reg, avs_writedata[15:0], avs_byteenable[1:0]);

  // mode field: software writes store the code only, no presets
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      operating_mode_field <= MODE_RST;
    else if (load_now)
      operating_mode_field <= mode_dec;
    else if (wr_fire && avs_address == ADDR_MODE && avs_byteenable[1])
      operating_mode_field <= avs_writedata[MODE_HI:MODE_LO];

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      indicator_scheme_select <= LEDS_RST;
    else if (wr_fire && avs_address == ADDR_MODE && avs_byteenable[0])
      indicator_scheme_select <= avs_writedata[LEDS_HI:LEDS_LO];

  // one wait cycle per access
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      ack_reg <= 1'b0;
    else if (ce)
      ack_reg <= (avs_read || avs_write) && !ack_reg;

  always_comb
  begin
    rd_val = 16'h0000;
    case (avs_address)
      ADDR_CTRL: rd_val = ctrl_reg;
      ADDR_ADV:  rd_val = adv_reg;
      ADDR_GIG:  rd_val = gig_reg;
      ADDR_MODE:
      begin
        rd_val[MODE_HI:MODE_LO] = operating_mode_field;
        rd_val[LEDS_HI:LEDS_LO] = indicator_scheme_select;
      end
      ADDR_STAT:
        rd_val = {8'h00, link_in.link_up, link_in.speed,
                  link_in.duplex_resolved, link_in.duplex_full,
                  carrier_sense_out, state_reg == MSDLS_ST_RUN, act_str};
      default:   rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      avs_readdata <= 32'h0;
    else if (rd_fire)
      avs_readdata <= {16'h0000, rd_val};

  // duplex from the forced bit, or from negotiation when enabled
  assign full_dup = ctrl_reg[CTRL_ANEN_BIT] ? link_in.duplex_full
                                            : ctrl_reg[CTRL_DUP_BIT];

  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      carrier_sense_out <= 1'b0;
    else if (ce)
      carrier_sense_out <= link_in.rx_active
                           || (link_in.tx_active && !full_dup);

  assign act_raw = link_in.tx_active || link_in.rx_active;

  msdls_blink #(
    .BLINK_CYC   (BLINK_CYC),
    .MIX_CYC     (MIX_CYC),
    .STRETCH_LEN (STRETCH_LEN)
  ) u_blink (
    .clk           (clk),
    .resetn        (resetn),
    .ce            (ce),
    .act_in        (act_raw),
    .blink_phase   (blink_phase),
    .mix_phase     (mix_phase),
    .act_stretched (act_str)
  );

  // lamp conditions; speed lamps need a link, duplex only resolution
  assign s10    = link_in.link_up && link_in.speed == SPD_10;
  assign s100   = link_in.link_up && link_in.speed == SPD_100;
  assign s1000  = link_in.link_up && link_in.speed == SPD_1000;
  assign dfull  = link_in.duplex_resolved && link_in.duplex_full;
  assign act_on = act_str && blink_phase;

  // indicator drive
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      led_out <= '0;
    else if (ce)
    begin
      case (indicator_scheme_select)
        LEDS_ONE, LEDS_TWO:
        begin
          if (indicator_scheme_select == LEDS_ONE)
          begin
            led_out.fast <= s100 || (s10 && mix_phase);
            led_out.gig  <= s1000 || (s10 && !mix_phase);
          end
          else
          begin
            led_out.gig  <= s1000 || (s10 && mix_phase);
            led_out.fast <= s100 || (s10 && !mix_phase);
          end
          if (indicator_scheme_select == LEDS_TWO
              && link_in.collision)
          begin
            led_out.base   <= !mix_phase;
            led_out.duplex <= mix_phase;
          end
          else
          begin
            led_out.base   <= act_on;
            led_out.duplex <= dfull && !act_on;
          end
        end
        default:
        begin
          led_out.gig    <= s1000 && !act_on;
          led_out.fast   <= s100 && !act_on;
          led_out.base   <= s10 && !act_on;
          led_out.duplex <= dfull;
        end
      endcase
    end

endmodule

// ===== verif/msdls_board_model.sv
/*
  Board side of msdls_top: the strap wiring of the two mode pins and
  the four status lamps.
  Assumes the bench picks the wiring before reset is released.
*/
`timescale 1ns/10ps
module msdls_board_model
  import msdls_pkg::*;
(
  input  wire logic [1:0] wire_upper,
  input  wire logic [1:0] wire_lower,
  input  wire msdls_led_s led_out,
  output logic [1:0]      mode_pin_upper,
  output logic [1:0]      mode_pin_lower,
  output logic [2:0]      lit_count
);
  // each strap ties to ground, fast lamp, gig lamp or supply
  assign mode_pin_upper = wire_upper;
  assign mode_pin_lower = wire_lower;
  assign lit_count = 3'(led_out.gig) + 3'(led_out.fast) +
                     3'(led_out.base) + 3'(led_out.duplex);
endmodule

// ===== verif/msdls_top_asserts.sv
/*
  Port-level assertions for msdls_top.
  Assumes one clock domain; bound to every msdls_top instance.
*/
`timescale 1ns/10ps
module msdls_top_asserts
  import msdls_pkg::*;
#(
  parameter int unsigned BLINK_CYC   = 4,
  parameter int unsigned MIX_CYC     = 2,
  parameter int unsigned STRETCH_LEN = 8
)(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic [1:0]  mode_pin_upper,
  input wire logic [1:0]  mode_pin_lower,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire msdls_link_s link_in,
  input wire logic        carrier_sense_out,
  input wire msdls_led_s  led_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic rq = avs_read | avs_write;

  a_wait_once: assert property (ce && rq && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait longer than one cycle");
  a_idle_nowait: assert property (!rq |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_upper_zero: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:16] == 16'h0000) else $error("upper half set");
  a_rdata_hold: assert property (ce && !(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data moved");
  a_crs_rx: assert property (ce && link_in.rx_active
    |=> carrier_sense_out) else $error("carrier missing on receive");
  a_crs_idle: assert property (ce && !link_in.rx_active && !link_in.tx_active
    |=> !carrier_sense_out) else $error("carrier without activity");
  a_speed_link: assert property (ce && !link_in.link_up
    |=> !led_out.gig && !led_out.fast) else $error("speed lamp without link");
  a_dup_resolved: assert property (ce && !link_in.duplex_resolved
    && !link_in.collision |=> !led_out.duplex) else $error("duplex lamp early");

  c_read_ack: cover property (avs_read && !avs_waitrequest);
  c_crs_rise: cover property ($rose(carrier_sense_out));
  c_dup_only: cover property (led_out.duplex && !led_out.gig);
endmodule

bind msdls_top msdls_top_asserts #(.BLINK_CYC(BLINK_CYC), .MIX_CYC(MIX_CYC),
  .STRETCH_LEN(STRETCH_LEN)) i_msdls_top_asserts (.clk(clk),
  .resetn(resetn), .ce(ce), .mode_pin_upper(mode_pin_upper),
  .mode_pin_lower(mode_pin_lower), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .link_in(link_in), .carrier_sense_out(carrier_sense_out),
  .led_out(led_out));

// ===== verif/msdls_top_tb_top.sv
/*
  Self-checking bench for msdls_top: strap decode and presets, register
  bus, carrier sense and the three lamp schemes.
  Assumes short blink, mix and stretch counts set below.
*/
`timescale 1ns/10ps
module msdls_top_tb_top;
  import msdls_pkg::*;
  logic        clk, resetn, ce, avs_read, avs_write;
  logic [1:0]  wire_upper, wire_lower, pin_up, pin_lo;
  logic [7:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic        avs_waitrequest, carrier_sense_out;
  msdls_link_s link_in;
  msdls_led_s  led_out;
  logic [2:0]  lit_count;
  logic [15:0] rdv;
  int          failures, n_tests, k, i, hi;
  logic [4:0]  e_mode [8] = '{5'h00, 5'h01, 5'h02, 5'h03,
                              5'h07, 5'h04, 5'h09, 5'h0A};
  logic [15:0] e_ctrl [8] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100,
                              16'h1040, 16'h3000, 16'h1040, 16'h1040};
  logic [15:0] e_gig  [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0300, 16'h0000, 16'h1300, 16'h1F00};

  msdls_top #(.BLINK_CYC(4), .MIX_CYC(2), .STRETCH_LEN(8)) i_msdls_top (
    .clk(clk), .resetn(resetn), .ce(ce), .mode_pin_upper(pin_up),
    .mode_pin_lower(pin_lo), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_in(link_in),
    .carrier_sense_out(carrier_sense_out), .led_out(led_out));
  msdls_board_model i_msdls_board_model (.wire_upper(wire_upper),
    .wire_lower(wire_lower), .led_out(led_out), .mode_pin_upper(pin_up),
    .mode_pin_lower(pin_lo), .lit_count(lit_count));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task check(input string what, input logic [15:0] seen,
             input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // called just after a rising edge; holds the request until acked
  task bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rdv = avs_readdata[15:0];
    check("bus ack", 16'(i < 16), 16'h0001);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task rc(input string what, input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    check(what, rdv, e);
  endtask

  task boot(input logic [1:0] up, input logic [1:0] lo);
    wire_upper <= up;
    wire_lower <= lo;
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // pins move after the latch; registers must not follow
    wire_upper <= 2'h0;
  endtask

  task report_and_stop;
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end

  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_byteenable = 4'h3;
    avs_writedata = 32'h00000000;
    link_in = 8'h00;
    wire_upper = 2'h0;
    wire_lower = 2'h0;
    boot(2'h0, 2'h0);
    rc("undef mode", ADDR_MODE, 16'h3818);
    for (k = 0; k < 8; k++)
    begin
      boot(2'(2 + k / 4), 2'(k % 4));
      rc("mode", ADDR_MODE, {e_mode[k], 11'h018});
      rc("ctrl", ADDR_CTRL, e_ctrl[k]);
      rc("adv", ADDR_ADV, (k < 4) ? 16'h0000 : 16'h01E0);
      rc("gig", ADDR_GIG, e_gig[k]);
      if (k < 4)
      begin
        link_in <= 8'h04;
        repeat (2) @(posedge clk);
        check("crs tx", 16'(carrier_sense_out), 16'(k % 2 == 0));
        link_in <= 8'h02;
        repeat (2) @(posedge clk);
        check("crs rx", 16'(carrier_sense_out), 16'h0001);
        link_in <= 8'h00;
        @(posedge clk);
      end
    end
    bus(1'b1, ADDR_CTRL, 16'h9040);
    rc("soft reset", ADDR_CTRL, 16'h1040);
    bus(1'b1, ADDR_MODE, 16'h0018);
    rc("gig kept", ADDR_GIG, 16'h1F00);
    rc("mode wr", ADDR_MODE, 16'h0018);
    avs_byteenable <= 4'h2;
    bus(1'b1, ADDR_MODE, 16'h50FF);
    avs_byteenable <= 4'h3;
    rc("lane one", ADDR_MODE, 16'h5018);
    bus(1'b1, 8'h40, 16'hFFFF);
    rc("unmapped", 8'h40, 16'h0000);
    link_in <= 8'hD8;
    rc("status", ADDR_STAT, 16'h00DA);
    link_in <= 8'hD8;
    repeat (2) @(posedge clk);
    check("led gig", 16'(led_out), 16'h0009);
    check("lamps lit", 16'(lit_count), 16'h0002);
    link_in <= 8'h18;
    repeat (2) @(posedge clk);
    check("led resolved", 16'(led_out), 16'h0001);
    link_in <= 8'hDC;
    hi = 0;
    for (k = 0; k < 16; k++)
    begin
      @(posedge clk);
      hi += int'(led_out.gig === 1'b1);
    end
    check("blink", 16'(hi > 0 && hi < 16), 16'h0001);
    link_in <= 8'h98;
    bus(1'b1, ADDR_MODE, 16'h0008);
    repeat (12) @(posedge clk);
    check("dup one", 16'(led_out.duplex), 16'h0001);
    hi = 0;
    for (k = 0; k < 8; k++)
    begin
      @(posedge clk);
      check("mix", 16'(led_out.fast ^ led_out.gig), 16'h0001);
      hi += int'(led_out.fast === 1'b1);
    end
    check("duty", 16'(hi), 16'h0004);
    link_in <= 8'h99;
    @(posedge clk);
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      check("no col one", 16'(led_out.base), 16'h0000);
    end
    link_in <= 8'hB8;
    bus(1'b1, ADDR_MODE, 16'h0010);
    repeat (2) @(posedge clk);
    check("fast two", 16'({led_out.gig, led_out.fast}), 16'h0001);
    link_in <= 8'hB9;
    repeat (2) @(posedge clk);
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk);
      check("col", 16'(led_out.base ^ led_out.duplex), 16'h0001);
    end
    bus(1'b1, ADDR_MODE, 16'h0000);
    repeat (2) @(posedge clk);
    check("scheme zero", 16'(led_out), 16'h0005);
    report_and_stop;
  end
endmodule
